// [gao_pkg.sv]
package gao_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam longint unsigned CLK_HZ            = 64'd125000000;
	localparam longint unsigned ALARM_DELAY_S     = 64'd2;
	localparam longint unsigned ALARM_DELAY_CYC   = ALARM_DELAY_S * CLK_HZ;
	localparam longint unsigned KEY_HOLD_S        = 64'd3;
	localparam longint unsigned KEY_HOLD_CYC      = KEY_HOLD_S * CLK_HZ;
	localparam longint unsigned MAINT_TIMEOUT_H   = 64'd10;
	localparam longint unsigned SEC_PER_HOUR      = 64'd3600;
	localparam longint unsigned MAINT_TIMEOUT_CYC = MAINT_TIMEOUT_H * SEC_PER_HOUR * CLK_HZ;
	localparam longint unsigned INIT_CLEAR_MS     = 64'd1000;
	localparam longint unsigned INIT_CLEAR_CYC    = (INIT_CLEAR_MS * CLK_HZ + 64'd999) / 64'd1000;
	localparam int              TMR_W             = 29;
	localparam int              TMO_W             = 43;

	// ****************************************
	// Concentration scale, 1 count = 0.1 %FS
	// ****************************************
	localparam logic [15:0]        SETPOINT_RESET = 16'h00FA;
	localparam logic [15:0]        ZSUP_RESET     = 16'h003C;
	localparam logic signed [15:0] NEG_SUPP_LIMIT = 16'sh0064;

	// ****************************************
	// Loop levels in microamps
	// ****************************************
	localparam int UA_FAULT  = 500;
	localparam int UA_LOW    = 2500;
	localparam int UA_ZERO   = 4000;
	localparam int UA_GAIN   = 16;
	localparam int UA_CLAMP  = 22000;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_SETPOINT = 8'h04;
	localparam logic [7:0] REG_ZSUP     = 8'h08;
	localparam logic [7:0] REG_STATUS   = 8'h0C;
	localparam logic [7:0] REG_IRQ_STAT = 8'h10;
	localparam logic [7:0] REG_IRQ_CLR  = 8'h14;
	localparam logic [7:0] REG_IRQ_EN   = 8'h18;
	localparam logic [7:0] REG_LOOP     = 8'h1C;
	localparam logic [7:0] REG_DISPLAY  = 8'h20;

	localparam int CTRL_DELAY_EN   = 0;
	localparam int CTRL_ALARM_USED = 1;
	localparam int CTRL_INHIBIT    = 2;
	localparam int CTRL_TEST       = 3;
	localparam int CTRL_TEST_OUT   = 4;
	localparam int CTRL_MOUT_LSB   = 5;
	localparam int CTRL_MAINT_EXIT = 7;
	localparam int CTRL_REG_MAINT  = 8;
	localparam logic [31:0] CTRL_RESET = 32'h00000023;

	localparam int IRQ_ALARM_ON  = 0;
	localparam int IRQ_ALARM_OFF = 1;
	localparam int IRQ_FAULT     = 2;
	localparam int IRQ_TIMEOUT   = 3;
	localparam int IRQ_W         = 4;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {MOUT_LOW, MOUT_4MA, MOUT_HOLD, MOUT_LIVE} gao_mout_t;
	typedef enum logic [2:0] {ST_INIT, ST_DETECT, ST_FAULT, ST_USER_MAINT, ST_REG_MAINT} gao_state_t;

endpackage

// [gao_timer.sv]
`timescale 1ns/100ps
module gao_timer #(
	parameter int          W     = 29,
	parameter logic [63:0] LIMIT = 64'h0000000000000001
) (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Control
	input  wire logic run,
	output logic      done
);

	localparam logic [W-1:0] LIM = LIMIT[W-1:0];

	logic [W-1:0] count;

	// Counts cycles of run, done after LIM cycles
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
			done  <= 1'b0;
		end else if (!run) begin
			count <= '0;
			done  <= 1'b0;
		end else if (!done) begin
			count <= count + 1'b1;
			done  <= (count + 1'b1) >= LIM;
		end
	end

endmodule

// [gao_top.sv]
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
// Summary of operation
// - Alarm, red lamp, contact at or above setpoint
// - Alarm and contact release below setpoint
// - Optional two second alarm delay
// - Green power lamp always lit
// - Fault lights yellow lamp, loop 0.5 mA
// - Fault clearing restarts initial clear
// - Fault message shows fault kind
// - Init and skip output 2.5 or 4 mA
// - Detection drives linear 4-20 mA
// - Over scale linear, clamped at 22 mA
// - Alarm test output live or 4 mA
// - Maintenance output low, 4, hold, live
// - Readings below suppression value show zero
// - Maintenance modes show unsuppressed reading
// - Negatives suppressed, at or beyond 10% show -0.0
// - Maintenance returns to detection after ten hours
module gao_top #(
	parameter logic [63:0] ALARM_DELAY_CYC   = gao_pkg::ALARM_DELAY_CYC,
	parameter logic [63:0] KEY_HOLD_CYC      = gao_pkg::KEY_HOLD_CYC,
	parameter logic [63:0] MAINT_TIMEOUT_CYC = gao_pkg::MAINT_TIMEOUT_CYC,
	parameter logic [63:0] INIT_CLEAR_CYC    = gao_pkg::INIT_CLEAR_CYC
) (
	// Clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// APB slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic      [31:0]        prdata,
	output logic                    pready,
	output logic                    pslverr,
	// Sensor side
	input  wire logic signed [15:0] concentration,
	input  wire logic               fault_detect,
	input  wire logic [3:0]         fault_code,
	// Operator key pin
	input  wire logic               mode_exit_key,
	// Lamps and contact
	output logic                    power_lamp,
	output logic                    gas_alarm_lamp,
	output logic                    gas_alarm_contact,
	output logic                    fault_lamp,
	output logic      [3:0]         fault_message,
	// Loop and display
	output logic      [15:0]        loop_ua,
	output logic signed [15:0]      display_value,
	output logic                    display_neg_zero,
	// Interrupt
	output logic                    irq
);

	// ****************************************
	// Declarations
	// ****************************************
	gao_pkg::gao_state_t state;
	gao_pkg::gao_state_t next_state;
	gao_pkg::gao_mout_t  mout_sel;
	logic                key_meta;
	logic                key_sync;
	logic                key_prev;
	logic                key_press;
	logic                delay_en;
	logic                alarm_used;
	logic                inhibit;
	logic                alarm_test;
	logic                test_out_on;
	logic                exit_req;
	logic                reg_req;
	logic [15:0]         setpoint;
	logic [15:0]         zsup;
	logic [gao_pkg::IRQ_W-1:0] irq_stat;
	logic [gao_pkg::IRQ_W-1:0] irq_en;
	logic [gao_pkg::IRQ_W-1:0] irq_event;
	logic [gao_pkg::IRQ_W-1:0] irq_clr;
	logic                apb_wr;
	logic                apb_rd;
	logic [31:0]         rd_mux;
	logic                mapped;
	logic                above;
	logic                in_maint;
	logic                test_active;
	logic                delay_done;
	logic                key_held;
	logic                maint_timeout;
	logic                init_done;
	logic                gas_alarm;
	logic                next_gas_alarm;
	logic [15:0]         live_ua;
	logic [15:0]         next_loop;
	logic signed [15:0]  next_display;
	logic                next_neg_zero;

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [15:0] conc_to_ua(input logic signed [15:0] c);
		logic signed [31:0] ua;
		ua = 32'(gao_pkg::UA_ZERO) + 32'(c) * 32'(gao_pkg::UA_GAIN);
		if (ua < 32'(gao_pkg::UA_ZERO)) begin
			ua = 32'(gao_pkg::UA_ZERO);
		end
		if (ua > 32'(gao_pkg::UA_CLAMP)) begin
			ua = 32'(gao_pkg::UA_CLAMP);
		end
		return ua[15:0];
	endfunction

	function automatic logic [15:0] maint_level(input gao_pkg::gao_mout_t sel);
		return (sel == gao_pkg::MOUT_LOW) ? 16'(gao_pkg::UA_LOW) : 16'(gao_pkg::UA_ZERO);
	endfunction

	// ****************************************
	// Key synchroniser
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_meta <= 1'b0;
			key_sync <= 1'b0;
			key_prev <= 1'b0;
		end else begin
			key_meta <= mode_exit_key;
			key_sync <= key_meta;
			key_prev <= key_sync;
		end
	end

	assign key_press = key_sync & ~key_prev;

	// ****************************************
	// Timers
	// ****************************************
	assign above       = concentration >= $signed({1'b0, setpoint});
	assign in_maint    = (state == gao_pkg::ST_USER_MAINT) || (state == gao_pkg::ST_REG_MAINT);
	assign test_active = alarm_test && (state == gao_pkg::ST_DETECT);

	gao_timer #(.W(gao_pkg::TMR_W), .LIMIT(ALARM_DELAY_CYC)) u_delay_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.run     ((state == gao_pkg::ST_DETECT) && above),
		.done    (delay_done)
	);

	gao_timer #(.W(gao_pkg::TMR_W), .LIMIT(KEY_HOLD_CYC)) u_key_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (key_sync && (state == gao_pkg::ST_DETECT)),
		.done    (key_held)
	);

	gao_timer #(.W(gao_pkg::TMO_W), .LIMIT(MAINT_TIMEOUT_CYC)) u_maint_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (in_maint),
		.done    (maint_timeout)
	);

	gao_timer #(.W(gao_pkg::TMR_W), .LIMIT(INIT_CLEAR_CYC)) u_init_tmr (
		.pclk    (pclk),
		.presetn (presetn),
		.run     (state == gao_pkg::ST_INIT),
		.done    (init_done)
	);

	// ****************************************
	// Operating state
	// ****************************************
	always_comb begin
		next_state = state;
		unique case (state)
			gao_pkg::ST_INIT: begin
				if (fault_detect) begin
					next_state = gao_pkg::ST_FAULT;
				end else if (init_done) begin
					next_state = gao_pkg::ST_DETECT;
				end
			end
			gao_pkg::ST_DETECT: begin
				if (fault_detect) begin
					next_state = gao_pkg::ST_FAULT;
				end else if (key_held) begin
					next_state = gao_pkg::ST_USER_MAINT;
				end
			end
			gao_pkg::ST_FAULT: begin
				if (!fault_detect) begin
					next_state = gao_pkg::ST_INIT;
				end
			end
			gao_pkg::ST_USER_MAINT: begin
				if (fault_detect) begin
					next_state = gao_pkg::ST_FAULT;
				end else if (key_press || exit_req || maint_timeout) begin
					next_state = gao_pkg::ST_DETECT;
				end else if (reg_req) begin
					next_state = gao_pkg::ST_REG_MAINT;
				end
			end
			gao_pkg::ST_REG_MAINT: begin
				if (fault_detect) begin
					next_state = gao_pkg::ST_FAULT;
				end else if (key_press || exit_req || maint_timeout) begin
					next_state = gao_pkg::ST_DETECT;
				end
			end
			default: begin
				next_state = gao_pkg::ST_INIT;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= gao_pkg::ST_INIT;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************
	// Alarm, lamps and contact
	// ****************************************
	assign next_gas_alarm = (state == gao_pkg::ST_DETECT) && above && (!delay_en || delay_done);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gas_alarm         <= 1'b0;
			gas_alarm_lamp    <= 1'b0;
			gas_alarm_contact <= 1'b0;
			power_lamp        <= 1'b1;
			fault_lamp        <= 1'b0;
			fault_message     <= 4'h0;
		end else begin
			gas_alarm         <= next_gas_alarm;
			gas_alarm_lamp    <= next_gas_alarm || test_active;
			gas_alarm_contact <= (next_gas_alarm || test_active) && alarm_used;
			power_lamp        <= 1'b1;
			fault_lamp        <= next_state == gao_pkg::ST_FAULT;
			fault_message     <= (next_state == gao_pkg::ST_FAULT) ? fault_code : 4'h0;
		end
	end

	// ****************************************
	// Loop output
	// ****************************************
	assign live_ua = conc_to_ua(concentration);

	always_comb begin
		if (state == gao_pkg::ST_FAULT) begin
			next_loop = 16'(gao_pkg::UA_FAULT);
		end else if (in_maint) begin
			unique case (mout_sel)
				gao_pkg::MOUT_HOLD: next_loop = loop_ua;
				gao_pkg::MOUT_LIVE: next_loop = live_ua;
				default:            next_loop = maint_level(mout_sel);
			endcase
		end else if (test_active) begin
			next_loop = test_out_on ? live_ua : 16'(gao_pkg::UA_ZERO);
		end else if ((state == gao_pkg::ST_INIT) || inhibit) begin
			next_loop = maint_level(mout_sel);
		end else begin
			next_loop = live_ua;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			loop_ua <= 16'(gao_pkg::UA_ZERO);
		end else begin
			loop_ua <= next_loop;
		end
	end

	// ****************************************
	// Display suppression
	// ****************************************
	always_comb begin
		next_display  = concentration;
		next_neg_zero = 1'b0;
		if (!in_maint) begin
			if (concentration <= -gao_pkg::NEG_SUPP_LIMIT) begin
				next_display  = 16'sh0000;
				next_neg_zero = 1'b1;
			end else if (concentration < $signed({1'b0, zsup})) begin
				next_display  = 16'sh0000;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			display_value    <= 16'sh0000;
			display_neg_zero <= 1'b0;
		end else begin
			display_value    <= next_display;
			display_neg_zero <= next_neg_zero;
		end
	end

	// ****************************************
	// APB slave
	// ****************************************
	assign apb_wr = psel && penable && pready && pwrite;
	assign apb_rd = psel && penable && !pready;

	always_comb begin
		rd_mux = 32'h00000000;
		mapped = 1'b1;
		unique case (paddr)
			gao_pkg::REG_CTRL: begin
				rd_mux[gao_pkg::CTRL_DELAY_EN]   = delay_en;
				rd_mux[gao_pkg::CTRL_ALARM_USED] = alarm_used;
				rd_mux[gao_pkg::CTRL_INHIBIT]    = inhibit;
				rd_mux[gao_pkg::CTRL_TEST]       = alarm_test;
				rd_mux[gao_pkg::CTRL_TEST_OUT]   = test_out_on;
				rd_mux[gao_pkg::CTRL_MOUT_LSB+:2] = mout_sel;
			end
			gao_pkg::REG_SETPOINT: rd_mux[15:0] = setpoint;
			gao_pkg::REG_ZSUP:     rd_mux[15:0] = zsup;
			gao_pkg::REG_STATUS:   rd_mux[8:0] = {fault_message, state, fault_lamp, gas_alarm};
			gao_pkg::REG_IRQ_STAT: rd_mux[gao_pkg::IRQ_W-1:0] = irq_stat;
			gao_pkg::REG_IRQ_CLR:  rd_mux = 32'h00000000;
			gao_pkg::REG_IRQ_EN:   rd_mux[gao_pkg::IRQ_W-1:0] = irq_en;
			gao_pkg::REG_LOOP:     rd_mux[15:0] = loop_ua;
			gao_pkg::REG_DISPLAY:  rd_mux[16:0] = {display_neg_zero, display_value};
			default:               mapped = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= apb_rd;
			prdata  <= apb_rd && !pwrite ? rd_mux : 32'h00000000;
			pslverr <= apb_rd && !mapped;
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			delay_en    <= gao_pkg::CTRL_RESET[gao_pkg::CTRL_DELAY_EN];
			alarm_used  <= gao_pkg::CTRL_RESET[gao_pkg::CTRL_ALARM_USED];
			inhibit     <= gao_pkg::CTRL_RESET[gao_pkg::CTRL_INHIBIT];
			alarm_test  <= gao_pkg::CTRL_RESET[gao_pkg::CTRL_TEST];
			test_out_on <= gao_pkg::CTRL_RESET[gao_pkg::CTRL_TEST_OUT];
			mout_sel    <= gao_pkg::gao_mout_t'(gao_pkg::CTRL_RESET[gao_pkg::CTRL_MOUT_LSB+:2]);
			setpoint    <= gao_pkg::SETPOINT_RESET;
			zsup        <= gao_pkg::ZSUP_RESET;
			irq_en      <= '0;
		end else if (apb_wr) begin
			if (paddr == gao_pkg::REG_CTRL) begin
				delay_en    <= pwdata[gao_pkg::CTRL_DELAY_EN];
				alarm_used  <= pwdata[gao_pkg::CTRL_ALARM_USED];
				inhibit     <= pwdata[gao_pkg::CTRL_INHIBIT];
				alarm_test  <= pwdata[gao_pkg::CTRL_TEST];
				test_out_on <= pwdata[gao_pkg::CTRL_TEST_OUT];
				mout_sel    <= gao_pkg::gao_mout_t'(pwdata[gao_pkg::CTRL_MOUT_LSB+:2]);
			end
			if (paddr == gao_pkg::REG_SETPOINT) begin
				setpoint <= pwdata[15:0];
			end
			if (paddr == gao_pkg::REG_ZSUP) begin
				zsup <= pwdata[15:0];
			end
			if (paddr == gao_pkg::REG_IRQ_EN) begin
				irq_en <= pwdata[gao_pkg::IRQ_W-1:0];
			end
		end
	end

	// Write-one pulses for mode changes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exit_req <= 1'b0;
			reg_req  <= 1'b0;
		end else begin
			exit_req <= apb_wr && (paddr == gao_pkg::REG_CTRL) && pwdata[gao_pkg::CTRL_MAINT_EXIT];
			reg_req  <= apb_wr && (paddr == gao_pkg::REG_CTRL) && pwdata[gao_pkg::CTRL_REG_MAINT];
		end
	end

	// ****************************************
	// Interrupts
	// ****************************************
	always_comb begin
		irq_event = '0;
		irq_event[gao_pkg::IRQ_ALARM_ON]  = next_gas_alarm && !gas_alarm;
		irq_event[gao_pkg::IRQ_ALARM_OFF] = !next_gas_alarm && gas_alarm;
		irq_event[gao_pkg::IRQ_FAULT]     = (next_state == gao_pkg::ST_FAULT) && (state != gao_pkg::ST_FAULT);
		irq_event[gao_pkg::IRQ_TIMEOUT]   = maint_timeout && in_maint;
	end

	assign irq_clr = (apb_wr && (paddr == gao_pkg::REG_IRQ_CLR)) ? pwdata[gao_pkg::IRQ_W-1:0] : '0;

	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
			irq      <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_event;
			irq      <= |(irq_stat & irq_en);
		end
	end

endmodule

// [gao_properties.sv]
`timescale 1ns/100ps
module gao_properties #(
	parameter logic [63:0] ALARM_DELAY_CYC = gao_pkg::ALARM_DELAY_CYC
) (
	// Clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	// APB
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	// Sensor
	input wire logic signed [15:0] concentration,
	input wire logic               fault_detect,
	input wire logic [3:0]         fault_code,
	// Outputs
	input wire logic               power_lamp,
	input wire logic               gas_alarm_lamp,
	input wire logic               gas_alarm_contact,
	input wire logic               fault_lamp,
	input wire logic [3:0]         fault_message,
	input wire logic [15:0]        loop_ua,
	input wire logic               irq
);
	// ****************************************
	// Register shadows
	// ****************************************
	logic [6:0]  ctrl_sh;
	logic [15:0] sp_sh;
	logic [3:0]  en_sh;
	logic [31:0] above_cnt;
	logic [15:0] exp_live;
	logic        wr_done;
	assign wr_done = psel && penable && pready && pwrite;
	assign exp_live = (concentration > 16'sh0464) ? 16'h55F0 : 16'h0FA0 + {concentration[11:0], 4'h0};
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_sh <= 7'h23;
			sp_sh <= 16'h00FA;
			en_sh <= 4'h0;
		end else if (wr_done) begin
			if (paddr == gao_pkg::REG_CTRL) ctrl_sh <= pwdata[6:0];
			if (paddr == gao_pkg::REG_SETPOINT) sp_sh <= pwdata[15:0];
			if (paddr == gao_pkg::REG_IRQ_EN) en_sh <= pwdata[3:0];
		end
	end
	// Cycles the reading has stayed at or above the setpoint
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) above_cnt <= 32'h0;
		else if (concentration >= $signed(sp_sh)) above_cnt <= above_cnt + 32'h1;
		else above_cnt <= 32'h0;
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence apb_setup;
		psel && !penable;
	endsequence
	sequence apb_access;
		psel && penable;
	endsequence
	apb_wait_a: assert property (apb_setup ##1 apb_access |-> !pready ##1 pready)
		else $error("APB answer not after one wait state");
	power_on_a: assert property (power_lamp)
		else $error("power lamp dark");
	fault_out_a: assert property (fault_detect [*2] |=> fault_lamp && loop_ua == 16'h01F4 && fault_message == $past(fault_code))
		else $error("fault outputs wrong");
	contact_gate_a: assert property ($stable(ctrl_sh) |-> gas_alarm_contact == (gas_alarm_lamp && ctrl_sh[1]))
		else $error("alarm contact mismatch");
	loop_range_a: assert property (loop_ua <= 16'h55F0 && (loop_ua >= 16'h0FA0 || loop_ua == 16'h09C4 || loop_ua == 16'h01F4))
		else $error("loop level out of range");
	live_loop_a: assert property ($stable(concentration) && $stable(ctrl_sh) && ctrl_sh[6:5] != 2'h2 && loop_ua > 16'h0FA0
		|-> loop_ua == exp_live)
		else $error("loop not linear in reading");
	delay_min_a: assert property ($rose(gas_alarm_lamp) && ctrl_sh[0] && !ctrl_sh[3] && $stable(ctrl_sh)
		|-> 64'(above_cnt) >= ALARM_DELAY_CYC)
		else $error("alarm before delay ran out");
	release_a: assert property (!ctrl_sh[3] && concentration < $signed(sp_sh) |=> !gas_alarm_lamp)
		else $error("alarm not released");
	irq_mask_a: assert property ($past(en_sh) == 4'h0 |-> !irq)
		else $error("masked interrupt raised");
endmodule

bind gao_top gao_properties #(.ALARM_DELAY_CYC(ALARM_DELAY_CYC)) i_gao_properties (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .concentration(concentration), .fault_detect(fault_detect),
	.fault_code(fault_code), .power_lamp(power_lamp), .gas_alarm_lamp(gas_alarm_lamp),
	.gas_alarm_contact(gas_alarm_contact), .fault_lamp(fault_lamp), .fault_message(fault_message),
	.loop_ua(loop_ua), .irq(irq)
);

// [gao_central.sv]
`timescale 1ns/100ps
module gao_central #(
	parameter int HOLD = 14
) (
	// Clock
	input wire logic        pclk,
	// Head outputs
	input wire logic [15:0] loop_ua,
	input wire logic        gas_alarm_contact,
	// Operator request
	input wire logic        press,
	output logic            mode_exit_key,
	// Observed state
	output logic            alarm_seen,
	output logic            fault_seen
);
	int hold_cnt = 0;
	// Operator keeps the key down for the whole span
	always_ff @(posedge pclk) begin
		if (press) hold_cnt <= HOLD;
		else if (hold_cnt > 0) hold_cnt <= hold_cnt - 1;
	end
	assign mode_exit_key = (hold_cnt > 0);
	// Loop below 1 mA reads as a head fault
	assign fault_seen = (loop_ua < 16'h03E8);
	assign alarm_seen = gas_alarm_contact;
endmodule

// [testbench.sv]
`timescale 1ns/100ps
`define CHK(a, e) if ((a) !== (e)) begin fails++; $display("ERROR %0t got %0h exp %0h", $time, a, e); end n_tests++
module testbench;
	// ****************************************
	// Signals
	// ****************************************
	logic               pclk = 1'b0;
	logic               presetn = 1'b0;
	logic               psel = 1'b0;
	logic               penable = 1'b0;
	logic               pwrite = 1'b0;
	logic [7:0]         paddr = 8'h00;
	logic [31:0]        pwdata = 32'h0;
	logic signed [15:0] concentration = 16'sh0000;
	logic               fault_detect = 1'b0;
	logic [3:0]         fault_code = 4'h0;
	logic               press = 1'b0;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               power_lamp;
	logic               gas_alarm_lamp;
	logic               gas_alarm_contact;
	logic               fault_lamp;
	logic [3:0]         fault_message;
	logic [15:0]        loop_ua;
	logic signed [15:0] display_value;
	logic               display_neg_zero;
	logic               irq;
	logic               mode_exit_key;
	logic               alarm_seen;
	logic               fault_seen;
	logic [31:0]        r;
	logic               e;
	int                 fails = 0;
	int                 n_tests = 0;
	localparam logic [7:0]  RA [4] = '{gao_pkg::REG_CTRL, gao_pkg::REG_SETPOINT, gao_pkg::REG_ZSUP, gao_pkg::REG_IRQ_EN};
	localparam logic [31:0] RV [4] = '{32'h23, 32'hFA, 32'h3C, 32'h0};
	localparam logic [15:0] CV [8] = '{16'h0000, 16'h003B, 16'h003C, 16'h03E8, 16'h0465, 16'h04B0, 16'hFF9D, 16'hFF9C};
	localparam logic [15:0] LV [8] = '{16'h0FA0, 16'h1350, 16'h1360, 16'h4E20, 16'h55F0, 16'h55F0, 16'h0FA0, 16'h0FA0};
	localparam logic [15:0] DV [8] = '{16'h0000, 16'h0000, 16'h003C, 16'h03E8, 16'h0465, 16'h04B0, 16'h0000, 16'h0000};
	localparam logic [1:0]  MO [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
	localparam logic [15:0] ML [4] = '{16'h1180, 16'h1180, 16'h09C4, 16'h0FA0};

	gao_top #(.ALARM_DELAY_CYC(64'h14), .KEY_HOLD_CYC(64'hA), .MAINT_TIMEOUT_CYC(64'h64), .INIT_CLEAR_CYC(64'hA)) i_gao_top (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .concentration(concentration),
		.fault_detect(fault_detect), .fault_code(fault_code), .mode_exit_key(mode_exit_key),
		.power_lamp(power_lamp), .gas_alarm_lamp(gas_alarm_lamp), .gas_alarm_contact(gas_alarm_contact),
		.fault_lamp(fault_lamp), .fault_message(fault_message), .loop_ua(loop_ua),
		.display_value(display_value), .display_neg_zero(display_neg_zero), .irq(irq));
	gao_central i_gao_central (.pclk(pclk), .loop_ua(loop_ua), .gas_alarm_contact(gas_alarm_contact),
		.press(press), .mode_exit_key(mode_exit_key), .alarm_seen(alarm_seen), .fault_seen(fault_seen));

	initial begin
		forever #4 pclk = ~pclk;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic st(input logic [2:0] s);
		apb(1'b0, gao_pkg::REG_STATUS, 32'h0);
		`CHK(r[4:2], s);
	endtask
	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		tick(4);
		presetn <= 1'b1;
		tick(1);
		`CHK(loop_ua, 16'h0FA0);
		`CHK(power_lamp, 1'b1);
		for (int j = 0; j < 4; j++) begin
			apb(1'b0, RA[j], 32'h0);
			`CHK(r, RV[j]);
		end
		apb(1'b1, 8'h24, 32'hFFFFFFFF);
		`CHK(e, 1'b1);
		apb(1'b0, 8'h24, 32'h0);
		`CHK(e, 1'b1);
		tick(14);
		st(3'h1);
		for (int j = 0; j < 8; j++) begin
			concentration <= CV[j];
			tick(2);
			`CHK(loop_ua, LV[j]);
			`CHK(display_value, DV[j]);
			`CHK(display_neg_zero, j == 7);
		end
		apb(1'b1, gao_pkg::REG_CTRL, 32'h22);
		apb(1'b1, gao_pkg::REG_IRQ_EN, 32'h1);
		concentration <= 16'sh00FA;
		tick(3);
		`CHK(gas_alarm_lamp, 1'b1);
		`CHK(alarm_seen, 1'b1);
		`CHK(irq, 1'b1);
		apb(1'b1, gao_pkg::REG_IRQ_CLR, 32'h1);
		tick(2);
		`CHK(irq, 1'b0);
		concentration <= 16'sh00F9;
		tick(2);
		`CHK(gas_alarm_lamp, 1'b0);
		`CHK(gas_alarm_contact, 1'b0);
		apb(1'b0, gao_pkg::REG_IRQ_STAT, 32'h0);
		`CHK(r[1:0], 2'h2);
		`CHK(irq, 1'b0);
		apb(1'b1, gao_pkg::REG_CTRL, 32'h20);
		concentration <= 16'sh012C;
		tick(2);
		`CHK(gas_alarm_lamp, 1'b1);
		`CHK(gas_alarm_contact, 1'b0);
		concentration <= 16'sh0000;
		apb(1'b1, gao_pkg::REG_CTRL, 32'h23);
		concentration <= 16'sh012C;
		tick(10);
		`CHK(gas_alarm_lamp, 1'b0);
		tick(14);
		`CHK(gas_alarm_lamp, 1'b1);
		apb(1'b1, gao_pkg::REG_CTRL, 32'h0A);
		concentration <= 16'sh01F4;
		tick(2);
		`CHK(loop_ua, 16'h0FA0);
		apb(1'b1, gao_pkg::REG_CTRL, 32'h1A);
		tick(2);
		`CHK(loop_ua, 16'h2EE0);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, gao_pkg::REG_CTRL, 32'h06 | (32'(m) << 5));
			tick(2);
			`CHK(loop_ua, (m == 0) ? 16'h09C4 : 16'h0FA0);
		end
		apb(1'b1, gao_pkg::REG_CTRL, 32'h06);
		fault_code <= 4'h5;
		fault_detect <= 1'b1;
		tick(3);
		`CHK(fault_lamp, 1'b1);
		`CHK(loop_ua, 16'h01F4);
		`CHK(fault_seen, 1'b1);
		`CHK(fault_message, 4'h5);
		st(3'h2);
		fault_detect <= 1'b0;
		tick(3);
		`CHK(fault_lamp, 1'b0);
		`CHK(loop_ua, 16'h09C4);
		st(3'h0);
		tick(12);
		st(3'h1);
		apb(1'b1, gao_pkg::REG_CTRL, 32'h02);
		concentration <= 16'sh001E;
		press <= 1'b1;
		tick(1);
		press <= 1'b0;
		tick(16);
		st(3'h3);
		`CHK(loop_ua, 16'h09C4);
		`CHK(display_value, 16'sh001E);
		for (int j = 0; j < 4; j++) begin
			apb(1'b1, gao_pkg::REG_CTRL, 32'h02 | (32'(MO[j]) << 5));
			if (j == 1) concentration <= 16'sh0064;
			tick(2);
			`CHK(loop_ua, ML[j]);
		end
		apb(1'b1, gao_pkg::REG_CTRL, 32'h122);
		st(3'h4);
		tick(110);
		st(3'h1);
		press <= 1'b1;
		tick(1);
		press <= 1'b0;
		tick(16);
		st(3'h3);
		apb(1'b1, gao_pkg::REG_CTRL, 32'h80);
		st(3'h1);
		test_done();
	end

	initial begin
		repeat (4000) @(posedge pclk);
		fails++;
		test_done();
	end
endmodule
